// File: logic/clockgen_watchdog_freq_ctrl.sv
/*
  Frequency control and watchdog registers of the clock generator.
  Assumes byte register accesses arrive from the serial engine on clk,
  and that the strap pins are asynchronous and steady around reset.
*/
`timescale 1ns/1ps
module clockgen_watchdog_freq_ctrl
  import clkgen_wdt_pkg::*;
#(
  parameter int unsigned SHORT_CYC = UNIT_SHORT_CYC,
  parameter int unsigned LONG_CYC  = UNIT_LONG_CYC
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire reg_req_t   regReq,
  output logic [7:0]      regRdata,
  input  wire logic [4:0] strapFreqPins,
  input  wire logic [8:0] recoveryValue,
  output cpu_cfg_t        cpuCfg,
  output logic            recoveryLoad,
  output logic            systemResetOutput_n
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [2:0] dynFreqMaxCap;
  logic       dynFreqOn;
  logic [3:0] softwareFreqCode;
  logic       restoreSel;
  logic       actionOnlyReset;
  logic       timeScale;
  logic       watchdogExpiredFlag;
  logic [2:0] watchdogCountField;
  logic       wdtEnable;
  logic [8:0] cpuMultiplierField;
  logic [6:0] cpuDividerField;
  logic       freqSourceOverride;
  logic       progCpuOn;
  logic       autoRecovery;

  // ----------------------------------------------------------------
  // Strap synchroniser and latch
  // ----------------------------------------------------------------
  logic [4:0] strapMeta;
  logic [4:0] strapSync;
  logic [4:0] strapLatched;
  logic       strapTaken;

  always_ff @(posedge clk) begin
    strapMeta <= strapFreqPins;
    strapSync <= strapMeta;
  end
  // Caught once after reset so later pin noise cannot move the ratio
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strapTaken   <= 1'b0;
      strapLatched <= 5'h00;
    end else if (!strapTaken) begin
      strapTaken   <= 1'b1;
      strapLatched <= strapSync;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wrDyn   = regReq.write && (regReq.addr == REG_DYN_FREQ);
  wire wrWdt   = regReq.write && (regReq.addr == REG_WDT_CTRL);
  wire wrMulLo = regReq.write && (regReq.addr == REG_MUL_LOW);
  wire wrMulHi = regReq.write && (regReq.addr == REG_MUL_HI_DIV);
  wire wrOvr   = regReq.write && (regReq.addr == REG_OVERRIDE);
  wire wrProg  = regReq.write && (regReq.addr == REG_PROG_CTRL);
  wire startLoad  = wrWdt && regReq.wdata[WDT_ENABLE_BIT];
  wire stopWrite  = wrWdt && !regReq.wdata[WDT_ENABLE_BIT];
  wire clearCount = wrWdt && (regReq.wdata[3:1] == 3'h0);

  // ----------------------------------------------------------------
  // Watchdog sequencer
  // ----------------------------------------------------------------
  wdt_state_t state;
  wdt_state_t next_state;
  logic [2:0] remaining;
  logic [4:0] pulseCount;
  logic       unitTick;
  logic       resetDrive;

  wire expire = (state == WDT_RUN) && !wrWdt && unitTick
                && (remaining == 3'h1);                          // RQ15
  always_comb begin
    next_state = state;
    case (state)
      WDT_IDLE: begin
        if (startLoad) next_state = WDT_RUN;                     // RQ8
      end
      WDT_RUN: begin
        if (stopWrite) next_state = WDT_IDLE;                    // RQ8
        else if (expire) next_state = WDT_FIRE;
      end
      WDT_FIRE: begin
        if (pulseCount == 5'h00) next_state = WDT_IDLE;
      end
      default: next_state = WDT_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= WDT_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // Test mode code 000 still runs one test unit of TEST_UNIT_CYC cycles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remaining <= 3'h0;
    end else if (startLoad && state != WDT_FIRE) begin
      remaining <= (regReq.wdata[3:1] == 3'h0) ? 3'h1
                                               : regReq.wdata[3:1]; // RQ7
    end else if (state == WDT_RUN && unitTick) begin
      remaining <= remaining - 3'h1;                             // RQ15
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulseCount <= 5'h00;
    end else if (expire) begin
      pulseCount <= RESET_PULSE_CYC - 5'h01;
    end else if (state == WDT_FIRE && pulseCount != 5'h00) begin
      pulseCount <= pulseCount - 5'h01;
    end
  end

  wdt_unit_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_unit (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .restart   (startLoad),
    .running   (state == WDT_RUN),
    .scaleLong (timeScale),
    .testMode  (watchdogCountField == 3'h0),
    .unitTick  (unitTick)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {dynFreqMaxCap, dynFreqOn, softwareFreqCode} <= DYN_FREQ_RST; // RQ2
      {cpuMultiplierField, cpuDividerField} <= {MUL_RST, MUL_RST}; // RQ11
      freqSourceOverride <= OVERRIDE_RST;                           // RQ13
      progCpuOn          <= PROG_CPU_RST;
      autoRecovery       <= AUTO_RST;                               // RQ14
    end else begin
      if (wrDyn) begin
        {dynFreqMaxCap, dynFreqOn, softwareFreqCode} <= regReq.wdata; // RQ1
      end
      if (wrMulLo) cpuMultiplierField[7:0] <= regReq.wdata;           // RQ11
      if (wrMulHi) begin
        {cpuMultiplierField[8], cpuDividerField} <= regReq.wdata;     // RQ11
      end
      if (wrOvr) freqSourceOverride <= regReq.wdata[OVERRIDE_BIT]; // RQ13
      if (wrProg) begin
        progCpuOn    <= regReq.wdata[PROG_CPU_BIT];                   // RQ12
        autoRecovery <= regReq.wdata[AUTO_RECOV_BIT];       // RQ14
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      restoreSel         <= WDT_CTRL_RST[WDT_RESTORE_BIT];
      actionOnlyReset    <= WDT_CTRL_RST[WDT_ACTION_BIT];
      timeScale          <= WDT_CTRL_RST[WDT_SCALE_BIT];            // RQ5
      watchdogCountField <= WDT_CTRL_RST[3:1];
    end else if (wrWdt) begin
      restoreSel         <= regReq.wdata[WDT_RESTORE_BIT];          // RQ3
      actionOnlyReset    <= regReq.wdata[WDT_ACTION_BIT];
      timeScale          <= regReq.wdata[WDT_SCALE_BIT];
      watchdogCountField <= regReq.wdata[3:1];
    end
  end
  // A control write blocks expiry in its cycle, so a clear wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdogExpiredFlag <= WDT_CTRL_RST[WDT_ALARM_BIT];
    end else if (expire) begin
      watchdogExpiredFlag <= 1'b1;                                  // RQ6
    end else if (clearCount) begin
      watchdogExpiredFlag <= 1'b0;                                  // RQ6
    end
  end
  // Enable reads back as the running state; expiry drops it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdtEnable <= WDT_CTRL_RST[WDT_ENABLE_BIT];
    end else if (wrWdt && state != WDT_FIRE) begin
      wdtEnable <= regReq.wdata[WDT_ENABLE_BIT];                    // RQ8
    end else if (expire) begin
      wdtEnable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  cpu_cfg_t next_cfg;
  logic [7:0] readMux;

  assign next_cfg.dynFreqOn     = dynFreqOn;                        // RQ1
  assign next_cfg.dynFreqMaxCap = dynFreqOn ? dynFreqMaxCap : 3'h0; // RQ1
  assign next_cfg.useProgrammed = progCpuOn;                        // RQ9
  assign next_cfg.multiplier    = progCpuOn ? cpuMultiplierField : 9'h000;
  assign next_cfg.divider       = progCpuOn ? cpuDividerField : 7'h00;
  assign next_cfg.ratioCode     = freqSourceOverride
                                  ? {1'b0, softwareFreqCode}
                                  : strapLatched;                   // RQ10
  assign next_cfg.restoreFromRecovery = restoreSel;                 // RQ3
  assign readMux =
    (regReq.addr == REG_DYN_FREQ)   ? {dynFreqMaxCap, dynFreqOn,
                                       softwareFreqCode} :
    (regReq.addr == REG_WDT_CTRL)   ? {restoreSel, actionOnlyReset, timeScale,
                                       watchdogExpiredFlag,
                                       watchdogCountField, wdtEnable} :
    (regReq.addr == REG_MUL_LOW)    ? cpuMultiplierField[7:0] :
    (regReq.addr == REG_MUL_HI_DIV) ? {cpuMultiplierField[8],
                                       cpuDividerField} :
    (regReq.addr == REG_OVERRIDE)   ? {2'h0, freqSourceOverride, 5'h00} :
    (regReq.addr == REG_PROG_CTRL)  ? {6'h00, progCpuOn, autoRecovery} :
                                      8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata     <= 8'h00;
      cpuCfg       <= '0;
      recoveryLoad <= 1'b0;
      resetDrive   <= 1'b0;
    end else begin
      if (regReq.read) regRdata <= readMux;
      cpuCfg       <= next_cfg;
      // Manual recovery leaves reload to software
      recoveryLoad <= expire && !actionOnlyReset && autoRecovery; // RQ4 RQ14
      resetDrive   <= (next_state == WDT_FIRE);                     // RQ4
    end
  end

  assign systemResetOutput_n = !resetDrive;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_alarm_on_expiry: assert property (expire |=> watchdogExpiredFlag) // RQ6
    else $error("alarm flag not set on expiry");
  a_alarm_cleared: assert property ( // RQ6
    clearCount && !expire |=> !watchdogExpiredFlag)
    else $error("alarm flag not cleared");
  a_reset_pulse_low: assert property ( // RQ4
    expire |=> (!systemResetOutput_n)[*8] ##1 (!systemResetOutput_n)[*8])
    else $error("reset pulse too short");
  a_reset_pulse_end: assert property ( // RQ4
    expire |-> ##17 systemResetOutput_n)
    else $error("reset pulse did not end");
  a_reload_on_action: assert property ( // RQ4 RQ14
    expire && !actionOnlyReset && autoRecovery |=> recoveryLoad)
    else $error("recovery reload missing");
  a_only_reset_kept: assert property ( // RQ4
    expire && actionOnlyReset |=> !recoveryLoad)
    else $error("reload despite reset-only action");
  a_enable_loads_count: assert property ( // RQ8
    startLoad && state != WDT_FIRE && regReq.wdata[3:1] != 3'h0
    |=> state == WDT_RUN && remaining == $past(regReq.wdata[3:1]))
    else $error("watchdog not loaded on enable");
  a_disable_stops: assert property ( // RQ8
    stopWrite && state == WDT_RUN |=> state == WDT_IDLE)
    else $error("watchdog not stopped");
  a_expiry_fires: assert property ( // RQ15
    expire |=> state == WDT_FIRE && !wdtEnable)
    else $error("expiry did not start the reset action");
  a_ratio_source: assert property ( // RQ10
    freqSourceOverride && $stable(softwareFreqCode)
    |=> cpuCfg.ratioCode == {1'b0, $past(softwareFreqCode)})
    else $error("ratio not from software code");
  a_prog_gate: assert property ( // RQ12
    !progCpuOn |=> !cpuCfg.useProgrammed
    && cpuCfg.multiplier == 9'h000 && cpuCfg.divider == 7'h00)
    else $error("programmed fields used while disabled");
  a_dyn_cap_gate: assert property ( // RQ1
    !dynFreqOn |=> cpuCfg.dynFreqMaxCap == 3'h0)
    else $error("dynamic cap passed while disabled");
  c_expiry: cover property (expire);
  c_reload: cover property (recoveryLoad);
  c_stop_mid_run: cover property (state == WDT_RUN ##1 stopWrite);

endmodule : clockgen_watchdog_freq_ctrl

// File: inc/clkgen_wdt_pkg.sv
/*
  Constants, register map and carrier types for the clock generator
  frequency control and watchdog block.
  Assumes a serial management engine that turns bus transfers into
  single byte register accesses on the 200 MHz internal clock.
*/
// Notes on behaviour
// RQ1 - Dynamic frequency enable bit 4 permits change, capped by bits 7 to 5.
// RQ2 - Four-bit software frequency code in bits 3 to 0, resetting to zero.
// RQ3 - Watchdog bit 7 picks restore: strapped setting or recovery value.
// RQ4 - Timeout pulses reset pin; action bit 0 also reloads, 1 only resets.
// RQ5 - Time unit bit 5: 0 is 294 ms, 1 is 2.34 s; powers up as 1.
// RQ6 - Alarm set on expiry, cleared when software clears the count field.
// RQ7 - Timeout is count field (bits 3 to 1) times unit; 000 is test mode.
// RQ8 - Writing enable bit 0 as 1 starts and loads watchdog; 0 disables it.
// RQ9 - Programmable mode takes CPU frequency from multiplier and divider.
// RQ10 - Override clear takes ratio from latched straps, set from software.
// RQ11 - Multiplier low byte in first register; bit 8 and divider in second.
// RQ12 - Programmable CPU enable bit gates use of multiplier and divider.
// RQ13 - Source override: 0 strap pins, 1 software code; powers up 0.
// RQ14 - Auto-recovery bit: 0 manual, 1 automatic; powers up as 1.
// RQ15 - Watchdog counts whole units, then raises alarm and does reset action.
package clkgen_wdt_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DYN_FREQ   = 8'h09;
  localparam logic [7:0] REG_WDT_CTRL   = 8'h0a;
  localparam logic [7:0] REG_MUL_LOW    = 8'h0b;
  localparam logic [7:0] REG_MUL_HI_DIV = 8'h0c;
  localparam logic [7:0] REG_OVERRIDE   = 8'h0e;
  localparam logic [7:0] REG_PROG_CTRL  = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DYN_ON_BIT       = 4;
  localparam int WDT_RESTORE_BIT  = 7;
  localparam int WDT_ACTION_BIT   = 6;
  localparam int WDT_SCALE_BIT    = 5;
  localparam int WDT_ALARM_BIT    = 4;
  localparam int WDT_ENABLE_BIT   = 0;
  localparam int OVERRIDE_BIT     = 5;
  localparam int PROG_CPU_BIT     = 1;
  localparam int AUTO_RECOV_BIT   = 0;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] DYN_FREQ_RST = 8'h00;
  localparam logic [7:0] WDT_CTRL_RST = 8'h20;
  localparam logic [7:0] MUL_RST      = 8'h00;
  localparam logic       OVERRIDE_RST = 1'b0;
  localparam logic       PROG_CPU_RST = 1'b0;
  localparam logic       AUTO_RST     = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_MHZ        = 200;
  localparam longint UNIT_SHORT_US  = 294000;
  localparam longint UNIT_LONG_US   = 2340000;
  localparam int unsigned UNIT_SHORT_CYC = 32'(UNIT_SHORT_US * CLK_MHZ);
  localparam int unsigned UNIT_LONG_CYC  = 32'(UNIT_LONG_US * CLK_MHZ);
  localparam int unsigned TEST_UNIT_CYC  = 32'h0000_0040;
  localparam logic [4:0]  RESET_PULSE_CYC = 5'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDT_IDLE = 2'b00,
    WDT_RUN  = 2'b01,
    WDT_FIRE = 2'b11
  } wdt_state_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       dynFreqOn;
    logic [2:0] dynFreqMaxCap;
    logic       useProgrammed;
    logic [8:0] multiplier;
    logic [6:0] divider;
    logic [4:0] ratioCode;
    logic       restoreFromRecovery;
  } cpu_cfg_t;

endpackage : clkgen_wdt_pkg

// File: logic/wdt_unit_timer.sv
/*
  Watchdog time-unit tick generator: one pulse per elapsed unit.
  Assumes the caller restarts it whenever the watchdog is loaded.
*/
`timescale 1ns/1ps
module wdt_unit_timer
  import clkgen_wdt_pkg::*;
#(
  parameter int unsigned SHORT_CYC = UNIT_SHORT_CYC,
  parameter int unsigned LONG_CYC  = UNIT_LONG_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic restart,
  input  wire logic running,
  input  wire logic scaleLong,
  input  wire logic testMode,
  output logic      unitTick
);

  // ----------------------------------------------------------------
  // Unit length
  // ----------------------------------------------------------------
  logic [31:0] unitLen;
  logic [31:0] count;
  wire         atEnd = (count == unitLen - 32'h0000_0001);

  assign unitLen = testMode  ? TEST_UNIT_CYC :
                   scaleLong ? LONG_CYC : SHORT_CYC;  // RQ5
  assign unitTick = running && !restart && atEnd;

  always_ff @(posedge clk) begin
    if (sys_rst || restart || !running || atEnd) begin
      count <= 32'h0000_0000;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end

endmodule : wdt_unit_timer

// File: sim/mgmt_host_model.sv
/*
  Management host model: issues single byte register accesses.
  Assumes the device takes a request on the edge where a strobe is high.
*/
`timescale 1ns/1ps
module mgmt_host_model
  import clkgen_wdt_pkg::*;
(
  input  wire logic       clk,
  output reg_req_t        regReq,
  input  wire logic [7:0] regRdata
);
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  initial regReq = '0;

  // Idle address and data show the inverse, so stale values never match
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    regReq = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
    @(posedge clk);
    #1;
    regReq = '{write: 1'b0, read: 1'b0, addr: ~addr, wdata: ~data};
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1;
    regReq = '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk);
    #1;
    regReq = '{write: 1'b0, read: 1'b0, addr: ~addr, wdata: 8'hff};
    @(posedge clk);
    #1;
    data = regRdata;
  endtask : reg_read
endmodule : mgmt_host_model

// File: sim/clockgen_watchdog_freq_ctrl_tb.sv
/*
  Self-checking bench for the frequency control and watchdog block.
  Assumes the host model drives the register port; unit counts shortened.
*/
`timescale 1ns/1ps
module clockgen_watchdog_freq_ctrl_tb import clkgen_wdt_pkg::*;;
  // ------------------------------------------------------------
  // Setup
  // ------------------------------------------------------------
  localparam int unsigned SHORT  = 40;
  localparam int unsigned LONG   = 100;
  localparam logic [4:0]  STRAPS = 5'h16;

  logic       clk;
  logic       sys_rst;
  reg_req_t   regReq;
  logic [7:0] regRdata;
  logic [4:0] strapFreqPins;
  logic [8:0] recoveryValue;
  cpu_cfg_t   cpuCfg;
  logic       recoveryLoad;
  logic       systemResetOutput_n;
  int         mismatches;
  int         cmp_count;
  logic [7:0] rd;
  logic [7:0] rstAddr [7];
  logic [7:0] rstVal  [7];

  clockgen_watchdog_freq_ctrl #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) dut (
    .clk                 (clk),
    .sys_rst             (sys_rst),
    .regReq              (regReq),
    .regRdata            (regRdata),
    .strapFreqPins       (strapFreqPins),
    .recoveryValue       (recoveryValue),
    .cpuCfg              (cpuCfg),
    .recoveryLoad        (recoveryLoad),
    .systemResetOutput_n (systemResetOutput_n)
  );

  mgmt_host_model host (
    .clk      (clk),
    .regReq   (regReq),
    .regRdata (regRdata)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : check

  task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
    host.reg_read(addr, rd);
    check($sformatf("register %h", addr), 32'(exp), 32'(rd));
  endtask : rd_check

  // Config output lags the registers by one edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Expiry time is only bracketed: the check allows up to four edges of slack
  task automatic run_wdt(input logic [7:0] ctrl, input logic expLoad);
    int   n;
    int   low;
    int   expCyc;
    logic seenLoad;
    n = 0;
    low = 0;
    seenLoad = 1'b0;
    expCyc = (ctrl[3:1] == 3'b000) ? int'(TEST_UNIT_CYC) :
             int'(ctrl[3:1]) * int'(ctrl[5] ? LONG : SHORT);
    host.reg_write(REG_WDT_CTRL, ctrl);
    while (systemResetOutput_n !== 1'b0 && n < expCyc + 20) begin
      @(posedge clk);
      #1;
      n++;
      seenLoad |= (recoveryLoad === 1'b1);
    end
    if (n >= expCyc + 20) begin
      mismatches++;
      final_report();
    end
    check("expiry", 32'h1, 32'(n >= expCyc && n <= expCyc + 4));
    while (systemResetOutput_n === 1'b0 && low < 40) begin
      @(posedge clk);
      #1;
      low++;
      seenLoad |= (recoveryLoad === 1'b1);
    end
    check("reset pulse length", 32'(RESET_PULSE_CYC), 32'(low));
    check("recovery reload", 32'(expLoad), 32'(seenLoad));
    rd_check(REG_WDT_CTRL, (ctrl | 8'h10) & 8'hfe);
    host.reg_write(REG_WDT_CTRL, ctrl & 8'he0);
    rd_check(REG_WDT_CTRL, ctrl & 8'he0);
  endtask : run_wdt

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int lows;
    sys_rst = 1'b1;
    strapFreqPins = STRAPS;
    recoveryValue = 9'h15a;
    mismatches = 0;
    cmp_count = 0;
    rstAddr = '{REG_DYN_FREQ, REG_WDT_CTRL, REG_MUL_LOW, REG_MUL_HI_DIV,
                REG_OVERRIDE, REG_PROG_CTRL, 8'h0d};
    rstVal = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    settle();
    check("reset pin idle", 32'h1, 32'(systemResetOutput_n));
    check("ratio from straps", 32'(STRAPS), 32'(cpuCfg.ratioCode));
    foreach (rstAddr[i]) rd_check(rstAddr[i], rstVal[i]);
    host.reg_write(8'h0d, 8'h5a);
    rd_check(8'h0d, 8'h00);
    host.reg_write(REG_DYN_FREQ, 8'h35);
    rd_check(REG_DYN_FREQ, 8'h35);
    check("dynamic enable", 32'h1, 32'(cpuCfg.dynFreqOn));
    check("dynamic cap", 32'h1, 32'(cpuCfg.dynFreqMaxCap));
    host.reg_write(REG_DYN_FREQ, 8'h25);
    settle();
    check("dynamic off", 32'h0, 32'(cpuCfg.dynFreqOn));
    check("cap when off", 32'h0, 32'(cpuCfg.dynFreqMaxCap));
    host.reg_write(REG_MUL_LOW, 8'ha5);
    host.reg_write(REG_MUL_HI_DIV, 8'hc3);
    rd_check(REG_MUL_LOW, 8'ha5);
    rd_check(REG_MUL_HI_DIV, 8'hc3);
    check("multiplier gated", 32'h0, 32'(cpuCfg.multiplier));
    host.reg_write(REG_PROG_CTRL, 8'hff);
    rd_check(REG_PROG_CTRL, 8'h03);
    check("programmed use", 32'h1, 32'(cpuCfg.useProgrammed));
    check("multiplier", 32'h1a5, 32'(cpuCfg.multiplier));
    check("divider", 32'h43, 32'(cpuCfg.divider));
    host.reg_write(REG_OVERRIDE, 8'hff);
    rd_check(REG_OVERRIDE, 8'h20);
    check("ratio from software", 32'h05, 32'(cpuCfg.ratioCode));
    host.reg_write(REG_OVERRIDE, 8'h00);
    settle();
    check("ratio to straps", 32'(STRAPS), 32'(cpuCfg.ratioCode));
    host.reg_write(REG_WDT_CTRL, 8'ha0);
    settle();
    check("restore source", 32'h1, 32'(cpuCfg.restoreFromRecovery));
    host.reg_write(REG_WDT_CTRL, 8'h20);
    settle();
    check("restore straps", 32'h0, 32'(cpuCfg.restoreFromRecovery));
    run_wdt(8'h03, 1'b1);
    run_wdt(8'h45, 1'b0);
    run_wdt(8'h01, 1'b1);
    run_wdt(8'h23, 1'b1);
    host.reg_write(REG_PROG_CTRL, 8'h02);
    run_wdt(8'h0f, 1'b0);
    // A rewrite while running must restart the full count
    host.reg_write(REG_WDT_CTRL, 8'h03);
    repeat (30) @(posedge clk);
    run_wdt(8'h03, 1'b0);
    host.reg_write(REG_WDT_CTRL, 8'h03);
    repeat (10) @(posedge clk);
    host.reg_write(REG_WDT_CTRL, 8'h02);
    lows = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      lows += (systemResetOutput_n !== 1'b1);
    end
    check("stopped watchdog quiet", 32'h0, 32'(lows));
    final_report();
  end
endmodule : clockgen_watchdog_freq_ctrl_tb
